/* rtl/sltg_pattern_gen.sv */
// serial lane test-pattern generator with apb control registers
// assumes: link layer and serdes status on mclk; powerdown_pin and
// sync_req_n arrive from pins and are synchronised here
//
// Function
// - sync header check is twelve-bit CRC or FEC
// - sync header mode can select FEC instead
// - power-down pin high disables all lane drivers
// - test select picks mode; lanes follow format
// - PRBS bypasses framing, scrambling and encoding
// - PRBS7 taps six and seven, period 127
// - PRBS9 taps five and nine, period 511
// - PRBS15 taps fourteen and fifteen
// - PRBS23 taps eighteen and twenty-three
// - PRBS31 taps twenty-eight and thirty-one
// - every lane seeds its PRBS differently
// - clock pattern eight ones, eight zeros, raw
// - ramp octet counter, same on all lanes
// - ramp starts after ILA or serdes init
// - short transport: k then FF minus k
// - transport pattern only on enabled lanes
// - D21.5 sent continuously under both codings
// - K28.5 sent continuously, 8b/10b only
// - repeated ILA restarts on each sync request
// - modified RPAT twelve-octet cycle, 8b/10b only
// - RPAT octets BE D7 23 47 6B 8F B3 14 5E FB 35 59
`timescale 1ns/1ps
`default_nettype none

module sltg_pattern_gen
  import sltg_pkg::*;
(
  input wire logic mclk, // 40 MHz system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic powerdown_pin, // power-down pin, async
  input wire logic sync_req_n, // receiver sync request pin, async
  input wire logic ila_done, // link layer finished ILA
  input wire logic serdes_ready, // serializers initialised
  input wire logic [15:0][7:0] tl_octet, // transport layer octets
  output sltg_lane_s [15:0] lane_out, // per-lane octet stream
  output logic sh_fec, // sync header carries FEC
  output logic sh_crc12, // sync header carries CRC-12
  output logic ilas_loop, // link layer repeats ILA
  output logic cgs_restart // pulse: restart code group sync
);

  sltg_ctrl_s ctrl;
  logic [3:0] test_sel;
  logic [7:0] link_format_mode;
  sltg_test_e active_test;
  logic [1:0] pd_sync;
  logic [1:0] sync_sync;
  logic pd_q;
  logic sync_q;
  logic relink_needed;
  logic ramp_run;
  logic [7:0] ramp_cnt;
  logic frame_sel;
  logic clk_phase;
  logic [3:0] rpat_idx;
  logic [15:0][30:0] prbs_st;
  logic [4:0] lane_cnt;
  logic pd_lvl;
  logic sync_lvl;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic is_prbs;
  logic need_8b10b;
  logic [31:0] next_prdata;
  logic [7:0] rpat_octet;

  assign pd_lvl = pd_sync[1];
  assign sync_lvl = sync_sync[1];

  // apb: one wait state, write takes effect with pready high, read data latched the cycle before
  assign wr_en = psel && penable && pready && pwrite;
  assign rd_en = psel && penable && !pready && !pwrite;
  assign addr_ok = (paddr == `SLTG_OFF_CTRL) || (paddr == `SLTG_OFF_TEST)
    || (paddr == `SLTG_OFF_FORMAT) || (paddr == `SLTG_OFF_STATUS);

  // lane count follows the link format mode whatever test runs
  always_comb begin
    unique case (link_format_mode)
      8'h05, 8'h2C, 8'h07, 8'h2D: lane_cnt = 5'd8;
      8'h06, 8'h32, 8'h08, 8'h33: lane_cnt = 5'd16;
      8'h22, 8'h23: lane_cnt = 5'd4;
      default: lane_cnt = 5'd8;
    endcase
  end

  // pseudo-random modes form one contiguous code range
  assign is_prbs = (active_test >= SLTG_PRBS7)
    && (active_test <= SLTG_PRBS31);

  // modes that only exist under 8b/10b coding
  assign need_8b10b = (test_sel == SLTG_K28) || (test_sel == SLTG_REP_ILA)
    || (test_sel == SLTG_RPAT);

  // octet handed to the encoder at each rpat position
  always_comb begin
    unique case (rpat_idx)
      4'h0: rpat_octet = 8'hBE;
      4'h1: rpat_octet = 8'hD7;
      4'h2: rpat_octet = 8'h23;
      4'h3: rpat_octet = 8'h47;
      4'h4: rpat_octet = 8'h6B;
      4'h5: rpat_octet = 8'h8F;
      4'h6: rpat_octet = 8'hB3;
      4'h7: rpat_octet = 8'h14;
      4'h8: rpat_octet = 8'h5E;
      4'h9: rpat_octet = 8'hFB;
      4'hA: rpat_octet = 8'h35;
      4'hB: rpat_octet = 8'h59;
      default: rpat_octet = 8'h00;
    endcase
  end

  // read mux, unmapped addresses read as zero
  always_comb begin
    next_prdata = 32'h0000_0000;
    unique case (paddr)
      `SLTG_OFF_CTRL: begin
        next_prdata[`SLTG_CTRL_LINK_EN] = ctrl.link_en;
        next_prdata[`SLTG_CTRL_ENC_66] = ctrl.enc_66;
        next_prdata[`SLTG_CTRL_SH_FEC] = ctrl.sh_fec;
      end
      `SLTG_OFF_TEST: next_prdata[3:0] = test_sel;
      `SLTG_OFF_FORMAT: next_prdata[7:0] = link_format_mode;
      `SLTG_OFF_STATUS: begin
        next_prdata[`SLTG_STAT_PD] = pd_lvl;
        next_prdata[`SLTG_STAT_ACT_LSB +: 4] = active_test;
        next_prdata[`SLTG_STAT_RAMP] = ramp_run;
        next_prdata[`SLTG_STAT_RELINK] = relink_needed;
        next_prdata[`SLTG_STAT_LANES_LSB +: 5] = lane_cnt;
      end
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  // eight PRBS steps per clock, first bit in octet msb
  function automatic logic [38:0] prbs_step8(input logic [30:0] st,
                                             input sltg_test_e mode);
    logic [30:0] s;
    logic [7:0] o;
    logic nb;
    s = st;
    o = 8'h00;
    for (int b = 7; b >= 0; b--) begin
      unique case (mode)
        SLTG_PRBS7: nb = s[5] ^ s[6];
        SLTG_PRBS9: nb = s[4] ^ s[8];
        SLTG_PRBS15: nb = s[13] ^ s[14];
        SLTG_PRBS23: nb = s[17] ^ s[22];
        default: nb = s[27] ^ s[30];
      endcase
      o[b] = nb;
      s = {s[29:0], nb};
    end
    return {o, s};
  endfunction : prbs_step8

  // two-flop synchronisers for the pins, then one edge flop each
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pd_sync <= 2'b00;
      sync_sync <= 2'b11;
      pd_q <= 1'b0;
      sync_q <= 1'b1;
    end else begin
      pd_sync <= {pd_sync[0], powerdown_pin};
      sync_sync <= {sync_sync[0], sync_req_n};
      pd_q <= pd_lvl;
      sync_q <= sync_lvl;
    end
  end

  // apb slave handshake and read data
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !addr_ok;
      if (rd_en) begin
        prdata <= next_prdata;
      end
    end
  end

  // control registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl <= `SLTG_RST_CTRL;
      test_sel <= `SLTG_RST_TEST;
      link_format_mode <= `SLTG_RST_FORMAT;
    end else if (wr_en) begin
      if (paddr == `SLTG_OFF_CTRL) begin
        ctrl.link_en <= pwdata[`SLTG_CTRL_LINK_EN];
        ctrl.enc_66 <= pwdata[`SLTG_CTRL_ENC_66];
        ctrl.sh_fec <= pwdata[`SLTG_CTRL_SH_FEC];
      end
      if (paddr == `SLTG_OFF_TEST) begin
        test_sel <= pwdata[`SLTG_TEST_SEL_LSB +: 4];
      end
      if (paddr == `SLTG_OFF_FORMAT) begin
        link_format_mode <= pwdata[7:0];
      end
    end
  end

  // selection is taken over only while the link is disabled
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      active_test <= SLTG_NORMAL;
    end else if (!ctrl.link_en) begin
      if (test_sel > SLTG_RPAT) begin
        active_test <= SLTG_NORMAL;
      end else if (need_8b10b && ctrl.enc_66) begin
        active_test <= SLTG_NORMAL;
      end else begin
        active_test <= sltg_test_e'(test_sel);
      end
    end
  end

  // sticky relink flag after power-down exit, write one clears
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      relink_needed <= 1'b0;
    end else if (pd_q && !pd_lvl) begin
      relink_needed <= 1'b1;
    end else if (wr_en && (paddr == `SLTG_OFF_STATUS)
                 && pwdata[`SLTG_STAT_RELINK]) begin
      relink_needed <= 1'b0;
    end
  end

  // sync header check selection, one bit so no three-bit CRC exists
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sh_fec <= 1'b0;
      sh_crc12 <= 1'b0;
    end else begin
      sh_fec <= ctrl.enc_66 && ctrl.sh_fec;
      sh_crc12 <= ctrl.enc_66 && !ctrl.sh_fec;
    end
  end

  // repeated ILA control towards the link layer
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ilas_loop <= 1'b0;
      cgs_restart <= 1'b0;
    end else begin
      ilas_loop <= (active_test == SLTG_REP_ILA);
      cgs_restart <= (active_test == SLTG_REP_ILA) && sync_q
        && !sync_lvl;
    end
  end

  // ramp start gate and octet counter
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ramp_run <= 1'b0;
      ramp_cnt <= 8'h00;
    end else if (active_test != SLTG_RAMP || !ctrl.link_en) begin
      ramp_run <= 1'b0;
      ramp_cnt <= 8'h00;
    end else if (!ramp_run) begin
      ramp_run <= ctrl.enc_66 ? serdes_ready : ila_done;
    end else begin
      ramp_cnt <= ramp_cnt + 8'h01;
    end
  end

  // frame, clock phase and RPAT position counters
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      frame_sel <= 1'b0;
      clk_phase <= 1'b0;
      rpat_idx <= 4'h0;
    end else begin
      frame_sel <= (active_test == SLTG_SHORT_TP) ? !frame_sel : 1'b0;
      clk_phase <= (active_test == SLTG_CLOCK) ? !clk_phase : 1'b0;
      if (active_test != SLTG_RPAT || rpat_idx == `SLTG_RPAT_LEN - 4'h1) begin
        rpat_idx <= 4'h0;
      end else begin
        rpat_idx <= rpat_idx + 4'h1;
      end
    end
  end

  generate
    // one generator, pattern mux and output flop per lane
    for (genvar i = 0; i < `SLTG_LANES; i++) begin : g_lane
      localparam logic [30:0] SEED = `SLTG_SEED_BASE
        ^ {24'h00_0000, 4'(i), 3'b000};
      logic [38:0] step;
      logic lane_on;
      sltg_lane_s next_lane;

      assign step = prbs_step8(prbs_st[i], active_test);
      // lanes 0-7 and 8-15 form two groups, lowest lanes first
      assign lane_on = 5'(i % `SLTG_GRP_LANES) < (lane_cnt >> 1);

      // reseed whenever no pseudo-random mode runs
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          prbs_st[i] <= SEED;
        end else if (!is_prbs) begin
          prbs_st[i] <= SEED;
        end else begin
          prbs_st[i] <= step[30:0];
        end
      end

      always_comb begin
        next_lane = '0;
        next_lane.drv_en = lane_on && !pd_lvl;
        unique case (active_test)
          SLTG_PRBS7, SLTG_PRBS9, SLTG_PRBS15, SLTG_PRBS23, SLTG_PRBS31:
          begin
            next_lane.octet = step[38:31];
            next_lane.raw = 1'b1;
          end
          SLTG_CLOCK: begin
            next_lane.octet = clk_phase ? `SLTG_CLK_LO : `SLTG_CLK_HI;
            next_lane.raw = 1'b1;
          end
          SLTG_RAMP: next_lane.octet = ramp_cnt;
          SLTG_SHORT_TP: begin
            if (lane_on) begin
              next_lane.octet = frame_sel
                ? 8'hFF - 8'(i % `SLTG_GRP_LANES)
                : 8'(i % `SLTG_GRP_LANES);
            end else begin
              next_lane.octet = 8'h00;
            end
          end
          SLTG_D21: next_lane.octet = `SLTG_D21_5;
          SLTG_K28: begin
            next_lane.octet = `SLTG_K28_5;
            next_lane.is_k = 1'b1;
          end
          SLTG_RPAT: next_lane.octet = rpat_octet;
          default: next_lane.octet = tl_octet[i];
        endcase
      end

      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          lane_out[i] <= '0;
        end else begin
          lane_out[i] <= next_lane;
        end
      end
    end
  endgenerate

endmodule : sltg_pattern_gen

`default_nettype wire

/* include/sltg_map.svh */
// register offsets, field positions, reset values and pattern constants
// assumes: included by the package; the test-pattern module uses its macros through it
`ifndef SLTG_MAP_SVH
`define SLTG_MAP_SVH

`define SLTG_OFF_CTRL 12'h000
`define SLTG_OFF_TEST 12'h004
`define SLTG_OFF_FORMAT 12'h008
`define SLTG_OFF_STATUS 12'h00C

`define SLTG_CTRL_LINK_EN 0
`define SLTG_CTRL_ENC_66 1
`define SLTG_CTRL_SH_FEC 2
`define SLTG_TEST_SEL_LSB 0
`define SLTG_STAT_PD 0
`define SLTG_STAT_ACT_LSB 4
`define SLTG_STAT_RAMP 8
`define SLTG_STAT_RELINK 9
`define SLTG_STAT_LANES_LSB 16

`define SLTG_RST_CTRL 3'h0
`define SLTG_RST_TEST 4'h0
`define SLTG_RST_FORMAT 8'h05

`define SLTG_CRC_WIDTH 12
`define SLTG_LANES 16
`define SLTG_GRP_LANES 8
`define SLTG_CLK_HI 8'hFF
`define SLTG_CLK_LO 8'h00
`define SLTG_D21_5 8'hB5
`define SLTG_K28_5 8'hBC
`define SLTG_RPAT_LEN 4'hC
`define SLTG_SEED_BASE 31'h2AC3_5E11

`endif

/* include/sltg_pkg.sv */
// types shared by the serial lane test-pattern logic
// assumes: sltg_map.svh on the include path
package sltg_pkg;
  `include "sltg_map.svh"

  typedef enum logic [3:0] {
    SLTG_NORMAL = 4'h0,
    SLTG_PRBS7 = 4'h1,
    SLTG_PRBS9 = 4'h2,
    SLTG_PRBS15 = 4'h3,
    SLTG_PRBS23 = 4'h4,
    SLTG_PRBS31 = 4'h5,
    SLTG_CLOCK = 4'h6,
    SLTG_RAMP = 4'h7,
    SLTG_SHORT_TP = 4'h8,
    SLTG_D21 = 4'h9,
    SLTG_K28 = 4'hA,
    SLTG_REP_ILA = 4'hB,
    SLTG_RPAT = 4'hC
  } sltg_test_e;

  // one octet per lane per clock towards the link layer and serializer
  typedef struct packed {
    logic [7:0] octet;
    logic is_k;
    logic raw;
    logic drv_en;
  } sltg_lane_s;

  typedef struct packed {
    logic link_en;
    logic enc_66;
    logic sh_fec;
  } sltg_ctrl_s;

endpackage : sltg_pkg

/* tb/sltg_pattern_gen_asserts.sv */
// port checker for the serial lane test-pattern block
// assumes: sltg_pkg compiled first; bound into sltg_pattern_gen
`timescale 1ns/1ps
`default_nettype none
module sltg_asserts
  import sltg_pkg::*;
(
  input wire logic mclk, // clock
  input wire logic rst_n, // reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access
  input wire logic [11:0] paddr, // apb address
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic powerdown_pin, // power-down pin
  input wire sltg_lane_s [15:0] lane_out, // lane streams
  input wire logic sh_fec, // fec header
  input wire logic sh_crc12, // crc header
  input wire logic ilas_loop, // ila repeat
  input wire logic cgs_restart // sync restart pulse
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic [15:0] drv;
  always_comb for (int i = 0; i < 16; i++) drv[i] = lane_out[i].drv_en;
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence pd_on_s;
    powerdown_pin [*4];
  endsequence
  sequence pd_off_s;
    !powerdown_pin [*5];
  endsequence
  AST_APB_WAIT: assert property (setup_s |-> ##2 pready)
    else $error("apb answer late");
  AST_APB_ERR: assert property (pready |->
    pslverr == (paddr > 12'h00C || paddr[1:0] != 2'b00))
    else $error("apb error flag wrong");
  AST_SH_EXCL: assert property (!(sh_fec && sh_crc12))
    else $error("both header checks on");
  AST_PD_OFF: assert property (pd_on_s |-> drv == 16'h0000)
    else $error("driver on in power-down");
  AST_PD_BACK: assert property (pd_off_s |-> drv[0])
    else $error("lane 0 driver off");
  AST_CGS_PULSE: assert property ($rose(cgs_restart) |=> !cgs_restart)
    else $error("sync restart too long");
  AST_CGS_ILA: assert property (cgs_restart |-> ilas_loop)
    else $error("sync restart outside ila mode");
  AST_K_ONLY: assert property (lane_out[0].is_k && !ilas_loop |->
    lane_out[0].octet == 8'hBC)
    else $error("control octet wrong");
endmodule : sltg_asserts
bind sltg_pattern_gen sltg_asserts chk_u (.mclk, .rst_n, .psel, .penable,
  .paddr, .pready, .pslverr, .powerdown_pin, .lane_out, .sh_fec,
  .sh_crc12, .ilas_loop, .cgs_restart);
`default_nettype wire

/* tb/sltg_rx_model.sv */
// receiver-side model: sync request pin and link-layer status
// assumes: same clock as the block; bench drives link_up and sync_go
`timescale 1ns/1ps
`default_nettype none
module sltg_rx_model (
  input wire logic mclk, // clock
  input wire logic rst_n, // reset, active low
  input wire logic link_up, // link enabled
  input wire logic sync_go, // ask for code group sync
  output logic sync_req_n, // sync request, active low
  output logic ila_done, // ila finished
  output logic serdes_ready // serializers up
);
  logic [3:0] cnt;
  always_ff @(posedge mclk) begin
    if (!rst_n || !link_up) begin
      cnt <= 4'h0;
      ila_done <= 1'b0;
    end else if (cnt != 4'hF) begin
      cnt <= cnt + 4'h1;
    end else begin
      ila_done <= 1'b1;
    end
  end
  always_ff @(posedge mclk) serdes_ready <= rst_n && link_up;
  always_ff @(posedge mclk) sync_req_n <= !(rst_n && sync_go);
endmodule : sltg_rx_model
`default_nettype wire

/* tb/test_serial_link_test_pattern_gen.sv */
// self-checking bench for the serial lane test-pattern block
// assumes: sltg_pkg, checker and receiver model compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
  $display("Error %0t: got %h want %h", $time, a, b); end end
module test_serial_link_test_pattern_gen;
  import sltg_pkg::*;
  logic mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, powerdown_pin = 1'b0, link_up = 1'b0;
  logic sync_go = 1'b0, pready, pslverr, sh_fec, sh_crc12, er;
  logic ilas_loop, cgs_restart, sync_req_n, ila_done, serdes_ready;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [15:0][7:0] tl_octet;
  sltg_lane_s [15:0] lane_out;
  logic [7:0] q [$];
  logic [7:0] dif;
  int err_total = 0, n_checks = 0;
  always #12.5 mclk = ~mclk;
  initial for (int i = 0; i < 16; i++) tl_octet[i] = 8'h40 + 8'(i);
  sltg_pattern_gen dut_u (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .powerdown_pin, .sync_req_n,
    .ila_done, .serdes_ready, .tl_octet, .lane_out, .sh_fec, .sh_crc12,
    .ilas_loop, .cgs_restart);
  sltg_rx_model rx_u (.mclk, .rst_n, .link_up, .sync_go, .sync_req_n,
    .ila_done, .serdes_ready);
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 9);
    if (pready !== 1'b1) begin
      err_total++;
      $display("Error %0t: apb answer missing", $time);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic set_test(input logic [3:0] c, input logic [2:0] ctl);
    apb(1'b1, 12'h000, 32'h0000_0000);
    link_up <= 1'b0;
    apb(1'b1, 12'h004, {28'h000_0000, c});
    repeat (3) @(posedge mclk);
    apb(1'b1, 12'h000, {29'h0000_0000, ctl});
    link_up <= ctl[0];
    repeat (3) @(posedge mclk);
  endtask : set_test
  task automatic grab(input int k, input int n);
    q.delete();
    dif = 8'h00;
    repeat (n) begin
      @(posedge mclk);
      q.push_back(lane_out[k].octet);
      dif |= lane_out[0].octet ^ lane_out[1].octet;
    end
  endtask : grab
  task automatic t_regs();
    apb(1'b0, 12'h008, '0);
    `CHK(rd, 32'h0000_0005)
    apb(1'b0, 12'h004, '0);
    `CHK(rd, 32'h0000_0000)
    apb(1'b1, 12'h010, 32'hFFFF_FFFF);
    `CHK(er, 1'b1)
    apb(1'b1, 12'h008, 32'h0000_0006);
    apb(1'b0, 12'h00C, '0);
    `CHK(rd[20:16], 5'h10)
    apb(1'b1, 12'h008, 32'h0000_0005);
  endtask : t_regs
  task automatic t_prbs();
    int ta [5] = '{6, 5, 14, 18, 28};
    int tz [5] = '{7, 9, 15, 23, 31};
    logic b [$];
    for (int m = 0; m < 5; m++) begin
      set_test(4'(m + 1), 3'h0);
      grab(1, 12);
      b.delete();
      foreach (q[i]) for (int j = 7; j >= 0; j--) b.push_back(q[i][j]);
      for (int n = 31; n < 96; n++)
        `CHK(b[n], b[n - ta[m]] ^ b[n - tz[m]])
      `CHK(lane_out[1].raw, 1'b1)
      `CHK(dif != 8'h00, 1'b1)
    end
  endtask : t_prbs
  task automatic t_chars();
    logic [7:0] rp [12] = '{8'hBE, 8'hD7, 8'h23, 8'h47, 8'h6B, 8'h8F,
      8'hB3, 8'h14, 8'h5E, 8'hFB, 8'h35, 8'h59};
    int k;
    set_test(4'h6, 3'h0);
    grab(2, 3);
    `CHK(q[0] ^ q[1], 8'hFF)
    `CHK({q[2] == q[0], q[0] == 8'hFF || q[0] == 8'h00}, 2'b11)
    `CHK(lane_out[2].raw, 1'b1)
    set_test(4'h9, 3'h2);
    grab(0, 2);
    `CHK(q[1], 8'hB5)
    set_test(4'hA, 3'h0);
    grab(0, 2);
    `CHK({lane_out[0].is_k, q[1]}, 9'h1BC)
    set_test(4'hA, 3'h2);
    grab(3, 2);
    `CHK(q[1], 8'h43)
    set_test(4'hC, 3'h0);
    grab(0, 24);
    k = 0;
    while (q[k] != 8'hBE && k < 11) k++;
    for (int i = 0; i < 12; i++) `CHK(q[k + i], rp[i])
  endtask : t_chars
  task automatic t_ramp();
    set_test(4'h7, 3'h3);
    apb(1'b0, 12'h00C, '0);
    `CHK(rd[8], 1'b1)
    set_test(4'h7, 3'h1);
    apb(1'b0, 12'h00C, '0);
    `CHK(rd[8], 1'b0)
    repeat (20) @(posedge mclk);
    grab(1, 3);
    `CHK(q[2] - q[1], 8'h01)
    `CHK(lane_out[1].raw, 1'b0)
    `CHK(lane_out[9].octet, lane_out[1].octet)
    apb(1'b0, 12'h00C, '0);
    `CHK(rd[8], 1'b1)
    set_test(4'h8, 3'h0);
    grab(2, 2);
    `CHK(q[0] ^ q[1], 8'hFF)
    `CHK(q[0] == 8'h02 || q[0] == 8'hFD, 1'b1)
    `CHK(lane_out[10].octet, lane_out[2].octet)
    `CHK({lane_out[4].drv_en, lane_out[4].octet}, 9'h000)
  endtask : t_ramp
  task automatic t_pd();
    apb(1'b1, 12'h000, 32'h0000_0006);
    repeat (2) @(posedge mclk);
    `CHK({sh_fec, sh_crc12}, 2'b10)
    apb(1'b1, 12'h000, 32'h0000_0002);
    repeat (2) @(posedge mclk);
    `CHK({sh_fec, sh_crc12}, 2'b01)
    powerdown_pin <= 1'b1;
    repeat (5) @(posedge mclk);
    `CHK(lane_out[0].drv_en, 1'b0)
    powerdown_pin <= 1'b0;
    repeat (5) @(posedge mclk);
    `CHK(lane_out[0].drv_en, 1'b1)
    apb(1'b0, 12'h00C, '0);
    `CHK(rd[9], 1'b1)
    apb(1'b1, 12'h00C, 32'h0000_0200);
    apb(1'b0, 12'h00C, '0);
    `CHK(rd[9], 1'b0)
  endtask : t_pd
  task automatic t_ila();
    int n;
    n = 0;
    set_test(4'hB, 3'h1);
    `CHK(ilas_loop, 1'b1)
    sync_go <= 1'b1;
    while (cgs_restart !== 1'b1 && n < 12) begin
      @(posedge mclk);
      n++;
    end
    `CHK(cgs_restart, 1'b1)
    sync_go <= 1'b0;
  endtask : t_ila
  task automatic print_verdict();
    if (err_total == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    t_regs();
    t_prbs();
    t_chars();
    t_ramp();
    t_pd();
    t_ila();
    print_verdict();
  end
  initial begin
    #100us;
    err_total++;
    print_verdict();
  end
endmodule : test_serial_link_test_pattern_gen
`default_nettype wire
